// ==== tkr_pkg.sv ====
// Function
// - BCD time keeping, 24-hour hours
// - date rolls over by month length, leap years
// - leap years correct through year 2100
// - 8k by 8 static memory array
// - everything reached through one byte-wide port
// - clock registers in top sixteen addresses
// - internal and external copies of time
// - host can freeze external copy updates
// - internal time keeps running while frozen
// - alarm match drives interrupt low
// - alarm on battery only when enabled
// - unserviced watchdog fires interrupt or reset
// - supply failure holds reset output low
// - reset output open drain, active low
// - interrupt output open drain, active low
// - supply failure deselects, accesses ignored
// - flag reports battery adequacy
// - read drives bus only with output enable
// - write while select and strobe low
// - reset held at least 40 ms after recovery
// - cell low flag read-only at 1FF0h bit 4
package tkr_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int WD_W = 7;
   typedef logic [7:0][7:0] tkr_time_t;
   // slots within a time vector
   localparam int T_SEC = 0;
   localparam int T_MIN = 1;
   localparam int T_HOUR = 2;
   localparam int T_DAY = 3;
   localparam int T_DATE = 4;
   localparam int T_MONTH = 5;
   localparam int T_YEAR = 6;
   localparam int T_CENT = 7;
   // clock register map, low nibble of the top block
   localparam logic [8:0] CLK_BLOCK = 9'h1FF;
   localparam logic [3:0] R_FLAGS = 4'h0;
   localparam logic [3:0] R_CENT = 4'h1;
   localparam logic [3:0] R_ALM_SEC = 4'h2;
   localparam logic [3:0] R_ALM_DATE = 4'h5;
   localparam logic [3:0] R_INT_EN = 4'h6;
   localparam logic [3:0] R_WDOG = 4'h7;
   localparam logic [3:0] R_CTRL = 4'h8;
   localparam logic [3:0] R_SEC = 4'h9;
   localparam int F_CELL_LOW = 4;
   localparam int F_ALARM = 6;
   localparam int F_WDOG = 7;
   localparam int C_WRITE = 7;
   localparam int C_READ = 6;
   localparam int E_ALARM = 7;
   localparam int E_BATT = 6;
   localparam int W_STEER = 7;
   // BCD limits
   localparam logic [7:0] MAX_SEC = 8'h59;
   localparam logic [7:0] MAX_HOUR = 8'h23;
   localparam logic [7:0] MAX_DAY = 8'h07;
   localparam logic [7:0] MAX_MONTH = 8'h12;
   localparam logic [7:0] MAX_YEAR = 8'h99;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] FEB = 8'h02;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic [7:0] CENT_RESET = 8'h20;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int RST_HOLD_MS = 40;
   localparam int RST_HOLD_CYCLES = CLK_HZ / 1000 * RST_HOLD_MS;
   localparam int SEC_CYCLES = CLK_HZ;
   localparam int CNT_W = 25;
endpackage

// ==== tkr_timekeeper.sv ====
`timescale 1ns/1ps
`default_nettype none

module tkr_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] IDLE = '0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] pin,
   output var logic [W-1:0] q
);
   logic [W-1:0] s1, s2, s3, next_q;
   always_comb begin
      // take a bit only once the last two stages agree, else keep it
      next_q = (s3 & (s2 ~^ s3)) | (q & (s2 ^ s3));
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         {s1, s2, s3, q} <= {4{IDLE}};
      end else begin
         {s3, s2, s1} <= {s2, s1, pin};
         q <= next_q;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module tkr_timekeeper
   import tkr_pkg::*;
#(
   parameter int SEC_TICKS = SEC_CYCLES,
   parameter int RST_HOLD = RST_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   // byte-wide host port
   input wire logic ceN,
   input wire logic oeN,
   input wire logic weN,
   input wire logic [ADDR_W-1:0] addrBus,
   input wire logic [DATA_W-1:0] byteBusIn,
   output var logic [DATA_W-1:0] byteBusOut,
   output var logic byteBusOe,
   // supply and battery monitors
   input wire logic powerFail,
   input wire logic onBattery,
   input wire logic cellLow,
   // open-drain outputs
   output var logic alarmWatchdogIntNOut,
   output var logic alarmWatchdogIntNOe,
   output var logic resetNOut,
   output var logic resetNOe
);
   localparam int SYNC_W = 3 + ADDR_W + DATA_W + 3;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'h7, {(SYNC_W - 3){1'b0}}};
   localparam logic [CNT_W-1:0] SEC_LAST = CNT_W'(SEC_TICKS - 1);
   localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RST_HOLD);
   logic sCeN, sOeN, sWeN, sPowerFail, sOnBattery, sCellLow;
   logic [ADDR_W-1:0] sAddr;
   logic [DATA_W-1:0] sData;

   tkr_pin_sync #(.W(SYNC_W), .IDLE(SYNC_IDLE)) pinSync (
      .clk(clk),
      .reset(reset),
      .pin({ceN, oeN, weN, addrBus, byteBusIn, powerFail, onBattery, cellLow}),
      .q({sCeN, sOeN, sWeN, sAddr, sData, sPowerFail, sOnBattery, sCellLow})
   );
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      if (v[3:0] == 4'h9)
         return {v[7:4] + 4'h1, 4'h0};
      return v + 8'h01;
   endfunction
   function automatic logic div4(input logic [7:0] v);
      if (v[4])
         return v[3:0] == 4'h2 || v[3:0] == 4'h6;
      return v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8;
   endfunction
   function automatic logic [7:0] monthLen(input tkr_time_t t);
      logic leap;
      // century years leap only when the century divides by four
      leap = (t[T_YEAR] == 8'h00) ? div4(t[T_CENT]) : div4(t[T_YEAR]);
      case (t[T_MONTH])
         FEB: monthLen = leap ? DAYS_29 : DAYS_28;
         8'h04, 8'h06, 8'h09, 8'h11: monthLen = DAYS_30;
         default: monthLen = DAYS_31;
      endcase
   endfunction

   function automatic tkr_time_t timeInc(input tkr_time_t t);
      tkr_time_t n;
      n = t;
      n[T_SEC] = bcdInc(t[T_SEC]);
      if (t[T_SEC] == MAX_SEC) begin
         n[T_SEC] = 8'h00;
         n[T_MIN] = bcdInc(t[T_MIN]);
         if (t[T_MIN] == MAX_SEC) begin
            n[T_MIN] = 8'h00;
            n[T_HOUR] = (t[T_HOUR] == MAX_HOUR) ? 8'h00 : bcdInc(t[T_HOUR]);
            if (t[T_HOUR] == MAX_HOUR) begin
               n[T_DAY] = (t[T_DAY] == MAX_DAY) ? BCD_ONE : bcdInc(t[T_DAY]);
               n[T_DATE] = bcdInc(t[T_DATE]);
               if (t[T_DATE] == monthLen(t)) begin
                  n[T_DATE] = BCD_ONE;
                  n[T_MONTH] = bcdInc(t[T_MONTH]);
                  if (t[T_MONTH] == MAX_MONTH) begin
                     n[T_MONTH] = BCD_ONE;
                     n[T_YEAR] = bcdInc(t[T_YEAR]);
                     if (t[T_YEAR] == MAX_YEAR) begin
                        n[T_YEAR] = 8'h00;
                        n[T_CENT] = bcdInc(t[T_CENT]);
                     end
                  end
               end
            end
         end
      end
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode, supply failure blocks every access
   logic selected, wrActive, rdActive, wrPrev, rdPrev, commit, rdDone;
   logic [ADDR_W-1:0] wrAddr, rdAddr, next_wrAddr, next_rdAddr;
   logic [DATA_W-1:0] wrData, next_wrData;
   logic clkWr, memWe;
   logic [3:0] regSel;

   always_comb begin
      selected = !sCeN && !sPowerFail;
      wrActive = selected && !sWeN;
      rdActive = selected && sWeN && !sOeN;
      // data is taken at the trailing edge, where it must be valid
      commit = wrPrev && !wrActive && !sPowerFail;
      rdDone = rdPrev && !rdActive;
      next_wrAddr = wrActive ? sAddr : wrAddr;
      next_wrData = wrActive ? sData : wrData;
      next_rdAddr = rdActive ? sAddr : rdAddr;
      clkWr = commit && wrAddr[ADDR_W-1:4] == CLK_BLOCK;
      memWe = commit && wrAddr[ADDR_W-1:4] != CLK_BLOCK;
      regSel = wrAddr[3:0];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPrev <= 1'b0;
         rdPrev <= 1'b0;
         wrAddr <= '0;
         wrData <= '0;
         rdAddr <= '0;
      end else begin
         wrPrev <= wrActive;
         rdPrev <= rdActive;
         wrAddr <= next_wrAddr;
         wrData <= next_wrData;
         rdAddr <= next_rdAddr;
      end
   end
   // retained contents, deliberately left out of reset
   logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1];
   always_ff @(posedge clk) begin
      if (memWe)
         mem[wrAddr] <= wrData;
   end

   ////////////////////////////////////////////////////////////////////////////
   // timekeeping, alarm, watchdog and supervisor state
   tkr_time_t intTime, extTime, next_intTime, next_extTime, tickTime;
   logic [7:0] alarm [0:3];
   logic [7:0] next_alarm [0:3];
   logic [7:0] ctrl, intEn, wdReg, next_ctrl, next_intEn, next_wdReg;
   logic [CNT_W-1:0] secCnt, holdCnt, next_secCnt, next_holdCnt;
   logic [WD_W-1:0] wdCnt, next_wdCnt;
   logic alarmFlag, wdFlag, next_alarmFlag, next_wdFlag;
   logic tick, frozen, match, wdExpire, flagsRead;

   always_comb begin
      tick = secCnt == SEC_LAST;
      next_secCnt = tick ? '0 : secCnt + CNT_W'(1);
      tickTime = tick ? timeInc(intTime) : intTime;
      next_intTime = tickTime;
      next_extTime = extTime;
      next_ctrl = ctrl;
      next_intEn = intEn;
      next_wdReg = wdReg;
      next_alarm = alarm;
      next_wdCnt = wdCnt;
      next_holdCnt = holdCnt;
      frozen = ctrl[C_WRITE] || ctrl[C_READ];
      flagsRead = rdDone && rdAddr == {CLK_BLOCK, R_FLAGS};
      if (clkWr) begin
         case (regSel)
            R_FLAGS: ;
            R_INT_EN: next_intEn = wrData;
            R_WDOG: next_wdReg = wrData;
            R_CTRL: next_ctrl = wrData;
            R_CENT: next_extTime[T_CENT] = wrData;
            default: begin
               if (regSel >= R_SEC)
                  next_extTime[3'(regSel - R_SEC)] = wrData;
               else
                  next_alarm[2'(regSel - R_ALM_SEC)] = wrData;
            end
         endcase
      end
      // whole-vector copy in one edge, never a partial value
      if (!frozen)
         next_extTime = tickTime;
      // releasing the write hold loads the host's time and restarts the second
      if (ctrl[C_WRITE] && !next_ctrl[C_WRITE]) begin
         next_intTime = extTime;
         next_secCnt = '0;
      end
      match = tick && tickTime[T_SEC] == alarm[0] && tickTime[T_MIN] == alarm[1]
         && tickTime[T_HOUR] == alarm[2] && tickTime[T_DATE] == alarm[3];
      // watchdog counts seconds; writing its register is the service
      wdExpire = tick && wdReg[WD_W-1:0] != '0 && wdCnt == WD_W'(1);
      if (clkWr && regSel == R_WDOG)
         next_wdCnt = wrData[WD_W-1:0];
      else if (wdExpire)
         next_wdCnt = wdReg[WD_W-1:0];
      else if (tick && wdCnt != '0)
         next_wdCnt = wdCnt - WD_W'(1);
      // new event wins over the clear from a flags read
      next_alarmFlag = match || (alarmFlag && !flagsRead);
      next_wdFlag = (wdExpire && !wdReg[W_STEER]) || (wdFlag && !flagsRead);
      if (sPowerFail || (wdExpire && wdReg[W_STEER]))
         next_holdCnt = HOLD_LOAD;
      else if (holdCnt != '0)
         next_holdCnt = holdCnt - CNT_W'(1);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         intTime <= {CENT_RESET, 8'h00, BCD_ONE, BCD_ONE, BCD_ONE, 24'h000000};
         extTime <= {CENT_RESET, 8'h00, BCD_ONE, BCD_ONE, BCD_ONE, 24'h000000};
         alarm <= '{default: 8'h00};
         ctrl <= 8'h00;
         intEn <= 8'h00;
         wdReg <= 8'h00;
         secCnt <= '0;
         wdCnt <= '0;
         holdCnt <= HOLD_LOAD;
         alarmFlag <= 1'b0;
         wdFlag <= 1'b0;
      end else begin
         intTime <= next_intTime;
         extTime <= next_extTime;
         alarm <= next_alarm;
         ctrl <= next_ctrl;
         intEn <= next_intEn;
         wdReg <= next_wdReg;
         secCnt <= next_secCnt;
         wdCnt <= next_wdCnt;
         holdCnt <= next_holdCnt;
         alarmFlag <= next_alarmFlag;
         wdFlag <= next_wdFlag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers; frequency-test output is not provided
   logic [DATA_W-1:0] readByte, next_byteBusOut;
   logic intAct, next_byteBusOe, next_intOe, next_rstOe;

   always_comb begin
      case (sAddr[3:0])
         R_FLAGS: readByte = {wdFlag, alarmFlag, 1'b0, sCellLow, 4'h0};
         R_CENT: readByte = extTime[T_CENT];
         R_INT_EN: readByte = intEn;
         R_WDOG: readByte = wdReg;
         R_CTRL: readByte = ctrl;
         default: begin
            if (sAddr[3:0] >= R_SEC)
               readByte = extTime[3'(sAddr[3:0] - R_SEC)];
            else
               readByte = alarm[2'(sAddr[3:0] - R_ALM_SEC)];
         end
      endcase
      if (sAddr[ADDR_W-1:4] != CLK_BLOCK)
         readByte = mem[sAddr];
      next_byteBusOut = rdActive ? readByte : byteBusOut;
      next_byteBusOe = rdActive;
      // on battery the alarm needs its wake-up enable
      intAct = (alarmFlag && intEn[E_ALARM] && (!sOnBattery || intEn[E_BATT]))
         || wdFlag;
      next_intOe = intAct;
      next_rstOe = sPowerFail || holdCnt != '0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         byteBusOut <= '0;
         byteBusOe <= 1'b0;
         alarmWatchdogIntNOe <= 1'b0;
         resetNOe <= 1'b1;
      end else begin
         byteBusOut <= next_byteBusOut;
         byteBusOe <= next_byteBusOe;
         alarmWatchdogIntNOe <= next_intOe;
         resetNOe <= next_rstOe;
      end
   end

   // open drain: only ever pull low
   assign alarmWatchdogIntNOut = 1'b0;
   assign resetNOut = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_fail_reset;
      sPowerFail |=> resetNOe ##1 resetNOe;
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("reset not held on fail");
   property p_hold_after;
      $fell(sPowerFail) |-> resetNOe [*8];
   endproperty
   a_hold_after: assert property (p_hold_after) else $error("reset released early");
   property p_rst_od;
      resetNOe |-> !resetNOut && alarmWatchdogIntNOut == resetNOut;
   endproperty
   a_rst_od: assert property (p_rst_od) else $error("open drain driven high");
   property p_deselect;
      sPowerFail |=> !byteBusOe;
   endproperty
   a_deselect: assert property (p_deselect) else $error("bus driven in fail");
   property p_no_fail_write;
      memWe || clkWr |-> !sPowerFail && $past(wrActive);
   endproperty
   a_no_fail_write: assert property (p_no_fail_write) else $error("write during fail");
   property p_read_drive;
      rdActive |=> byteBusOe;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read not driven");
   property p_idle_float;
      !rdActive |=> !byteBusOe;
   endproperty
   a_idle_float: assert property (p_idle_float) else $error("bus driven idle");
   property p_runs_frozen;
      tick && frozen && !clkWr |=> intTime != $past(intTime);
   endproperty
   a_runs_frozen: assert property (p_runs_frozen) else $error("time lost while frozen");
   property p_freeze;
      frozen && !clkWr |=> extTime == $past(extTime);
   endproperty
   a_freeze: assert property (p_freeze) else $error("copy moved while frozen");
   property p_sec_wrap;
      tick && intTime[T_SEC] == MAX_SEC && !clkWr |=> intTime[T_SEC] == 8'h00;
   endproperty
   a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap");
   property p_alarm_int;
      match && intEn[E_ALARM] && !sOnBattery |=> ##1 alarmWatchdogIntNOe;
   endproperty
   a_alarm_int: assert property (p_alarm_int) else $error("alarm not signalled");

   c_tick: cover property (tick && frozen);
   c_alarm: cover property (match ##2 alarmWatchdogIntNOe);
   c_write: cover property (wrActive ##[1:8] memWe);
   c_release: cover property ($fell(resetNOe));
endmodule

`default_nettype wire

// ==== tkr_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module tkr_host
   import tkr_pkg::*;
(
   // clock
   input wire logic clk,
   // host side of the byte-wide port
   output var logic ceN,
   output var logic oeN,
   output var logic weN,
   output var logic [ADDR_W-1:0] addrBus,
   output var logic [DATA_W-1:0] byteBusIn,
   // device read side
   input wire logic [DATA_W-1:0] byteBusOut,
   input wire logic byteBusOe
);
   logic [DATA_W-1:0] seen;

   initial begin
      ceN = 1'b1;
      oeN = 1'b1;
      weN = 1'b1;
      addrBus = '0;
      byteBusIn = 8'h00;
      seen = 8'h00;
   end

   ////////////////////////////////////////
   // each phase lasts 5 clocks, 6 for a read's first: the pins pass 4 sync flops
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk) #1;
      addrBus = a;
      byteBusIn = d;
      ceN = 1'b0;
      weN = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      ceN = 1'b1;
      weN = 1'b1;
      // address and data held until the late commit has passed
      repeat (5) @(posedge clk);
      #1;
      byteBusIn = ~d;
      addrBus = ~a;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic oe,
                     output logic [DATA_W-1:0] d, output logic drv);
      @(posedge clk) #1;
      addrBus = a;
      ceN = 1'b0;
      oeN = ~oe;
      repeat (6) @(posedge clk);
      drv = byteBusOe;
      // a floating bus shows no stale byte
      d = byteBusOe ? byteBusOut : ~seen;
      seen = d;
      #1;
      ceN = 1'b1;
      oeN = 1'b1;
      repeat (5) @(posedge clk);
      #1;
   endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module tb
   import tkr_pkg::*;
;
   localparam int SEC = 32;
   localparam int HOLD = 20;
   localparam int LIMIT = 20000;
   localparam logic [31:0] DAYS [4] = '{32'h20240228, 32'h21000228, 32'h20230430, 32'h20000228};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic powerFail = 1'b0;
   logic onBattery = 1'b0;
   logic cellLow = 1'b0;
   logic ceN, oeN, weN, byteBusOe, intOut, intOe, rstOut, rstOe, rdDrv, sawInt, sawRst;
   logic intPin, rstPin;
   logic [ADDR_W-1:0] addrBus, a;
   logic [DATA_W-1:0] byteBusIn, byteBusOut, rdData;
   logic [DATA_W-1:0] mem [int];
   tkr_time_t t, e;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'h7260017f;

   // open-drain pins with board pull-ups
   assign intPin = intOe ? intOut : 1'b1;
   assign rstPin = rstOe ? rstOut : 1'b1;

   always #20 clk = ~clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (intOe === 1'b1) begin
         sawInt <= 1'b1;
      end
      if (rstOe === 1'b1) begin
         sawRst <= 1'b1;
      end
      if (cycles == LIMIT) begin
         num_errors++;
         final_report();
      end
   end

   tkr_timekeeper #(.SEC_TICKS(SEC), .RST_HOLD(HOLD)) u_tkr_timekeeper (
      .clk(clk), .reset(reset), .ceN(ceN), .oeN(oeN), .weN(weN), .addrBus(addrBus),
      .byteBusIn(byteBusIn), .byteBusOut(byteBusOut), .byteBusOe(byteBusOe),
      .powerFail(powerFail), .onBattery(onBattery), .cellLow(cellLow),
      .alarmWatchdogIntNOut(intOut), .alarmWatchdogIntNOe(intOe),
      .resetNOut(rstOut), .resetNOe(rstOe));

   tkr_host u_tkr_host (.clk(clk), .ceN(ceN), .oeN(oeN), .weN(weN), .addrBus(addrBus),
      .byteBusIn(byteBusIn), .byteBusOut(byteBusOut), .byteBusOe(byteBusOe));

   ////////////////////////////////////////
   task automatic final_report();
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] ad);
      u_tkr_host.rd(ad, 1'b1, rdData, rdDrv);
   endtask

   task automatic wrc(input logic [3:0] off, input logic [DATA_W-1:0] d);
      u_tkr_host.wr({CLK_BLOCK, off}, d);
   endtask

   function automatic logic [ADDR_W-1:0] ra(input int i);
      return {CLK_BLOCK, (i == T_CENT) ? R_CENT : 4'(R_SEC + i)};
   endfunction

   // write hold keeps the half-written time out of the counters
   task automatic set_time(input tkr_time_t v);
      wrc(R_CTRL, 8'h80);
      for (int i = 0; i < 8; i++) begin
         u_tkr_host.wr(ra(i), v[i]);
      end
      wrc(R_CTRL, 8'h00);
   endtask

   function automatic logic [7:0] inc(input logic [7:0] b);
      return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
   endfunction

   function automatic int b2i(input logic [7:0] b);
      return b[7:4] * 10 + b[3:0];
   endfunction

   // day after v at 23:59:59; december is not handled
   function automatic tkr_time_t next_day(input tkr_time_t v);
      int y;
      logic [7:0] lim;
      tkr_time_t r;
      y = b2i(v[T_CENT]) * 100 + b2i(v[T_YEAR]);
      lim = (v[T_MONTH] inside {8'h04, 8'h06, 8'h09, 8'h11}) ? 8'h30 : 8'h31;
      if (v[T_MONTH] == 8'h02) begin
         lim = (y % 4 == 0 && (y % 100 != 0 || y % 400 == 0)) ? 8'h29 : 8'h28;
      end
      r = v;
      r[T_HOUR:T_SEC] = '0;
      r[T_DAY] = (v[T_DAY] == 8'h07) ? 8'h01 : v[T_DAY] + 8'h01;
      r[T_DATE] = (v[T_DATE] == lim) ? 8'h01 : inc(v[T_DATE]);
      r[T_MONTH] = (v[T_DATE] == lim) ? inc(v[T_MONTH]) : v[T_MONTH];
      return r;
   endfunction

   ////////////////////////////////////////
   initial begin
      sawInt = 1'b0;
      sawRst = 1'b0;
      idle(6);
      reset = 1'b0;
      `CHK(rstPin, 1'b0)
      `CHK(byteBusOe, 1'b0)
      `CHK(intPin, 1'b1)
      idle(HOLD - 2);
      `CHK(rstOe, 1'b1)
      idle(6);
      `CHK(rstPin, 1'b1)
      $display("test reset done");

      for (int i = 0; i < 24; i++) begin
         a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FEF : 13'($unsigned($random(seed)) % 32'h1FF0);
         mem[a] = 8'($random(seed));
         u_tkr_host.wr(a, mem[a]);
      end
      foreach (mem[k]) begin
         rd(13'(k));
         `CHK(rdDrv, 1'b1)
         `CHK(rdData, mem[k])
      end
      u_tkr_host.rd(13'h0000, 1'b0, rdData, rdDrv);
      `CHK(rdDrv, 1'b0)
      $display("test memory done");

      powerFail = 1'b1;
      idle(5);
      `CHK(rstOe, 1'b1)
      u_tkr_host.wr(13'h0000, ~mem[0]);
      rd(13'h0000);
      `CHK(rdDrv, 1'b0)
      powerFail = 1'b0;
      idle(HOLD);
      `CHK(rstOe, 1'b1)
      idle(10);
      `CHK(rstOe, 1'b0)
      rd(13'h0000);
      `CHK(rdData, mem[0])
      cellLow = 1'b1;
      wrc(R_FLAGS, 8'hFF);
      rd({CLK_BLOCK, R_FLAGS});
      `CHK(rdData & 8'h3F, 8'h10)
      cellLow = 1'b0;
      rd({CLK_BLOCK, R_FLAGS});
      `CHK(rdData & 8'h3F, 8'h00)
      $display("test supply done");

      for (int k = 0; k < 4; k++) begin
         t = {DAYS[k], 8'($unsigned($random(seed)) % 7 + 1), 24'h235959};
         set_time(t);
         idle(30);
         wrc(R_CTRL, 8'h40);
         e = next_day(t);
         for (int i = 0; i < 8; i++) begin
            rd(ra(i));
            `CHK(rdData, e[i])
         end
         wrc(R_CTRL, 8'h00);
         wrc(R_CTRL, 8'h40);
         rd(ra(T_SEC));
         `CHK(rdData > 8'h02, 1'b1)
         wrc(R_CTRL, 8'h00);
      end
      $display("test calendar done");

      for (int k = 0; k < 3; k++) begin
         onBattery = (k > 0);
         wrc(R_INT_EN, (k == 2) ? 8'hC0 : 8'h80);
         wrc(R_ALM_SEC, 8'h02);
         wrc(4'(R_ALM_SEC + 1), 8'h00);
         wrc(4'(R_ALM_SEC + 2), 8'h12);
         wrc(R_ALM_DATE, 8'h10);
         sawInt = 1'b0;
         set_time({32'h20240310, 8'h01, 24'h120000});
         idle(100);
         `CHK(sawInt, k != 1)
         rd({CLK_BLOCK, R_FLAGS});
         if (k != 1) begin
            `CHK(rdData[F_ALARM], 1'b1)
         end
         idle(3);
         `CHK(intPin, 1'b1)
      end
      onBattery = 1'b0;
      wrc(R_INT_EN, 8'h00);
      $display("test alarm done");

      // timeout of two seconds: one second could lapse at once
      for (int k = 0; k < 2; k++) begin
         sawInt = 1'b0;
         sawRst = 1'b0;
         for (int i = 0; i < 5; i++) begin
            wrc(R_WDOG, (k == 1) ? 8'h82 : 8'h02);
            idle(15);
         end
         `CHK(sawInt | sawRst, 1'b0)
         idle(3 * SEC);
         `CHK((k == 1) ? sawRst : sawInt, 1'b1)
         wrc(R_WDOG, 8'h00);
         idle(HOLD);
         rd({CLK_BLOCK, R_FLAGS});
         // the pin lets go two edges after the clearing read
         idle(3);
      end
      $display("test watchdog done");
      final_report();
   end
endmodule

`default_nettype wire
